// [logic/clock_output_adjust_and_reset.sv]
// Soft reset sequencer and per-output frequency, phase and spread control
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Writing 0x02 to 0xf6 starts soft reset
// - Soft reset bit stays set, never self-clears
// - Soft reset leaves every register unchanged
// - Disable, calibrate, wait lock, re-enable outputs
// - Unity post-divider outputs aligned during reset
// - Per-output frequency steps in 1 ppm units
// - Frequency pins act on first output only
// - Pin steps accepted up to 1.5 MHz
// - Frequency steps exact and glitchless
// - Phase adjust 20 ps steps, 45 ns range
// - Pin phase steps accepted up to 1.5 MHz
// - Initial phase offset only when ratio one
// - Falling-edge sync; inversion gives rising edge
// - Post-divider ratios one through thirty-two
// - Effective step divided by post-divider ratio
// - Zero-delay feedback routing from one output
// - Spread per output, center or down limits
// - Spread rate held within 30 to 63 kHz
// - Default spread is 31.5 kHz profile
// - Center spread by upshift plus down spread
module clock_output_adjust_and_reset
	import clock_adjust_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_WAIT_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic freq_step_up_pin,
	input wire logic freq_step_down_pin,
	input wire logic phase_step_up_pin,
	input wire logic phase_step_down_pin,
	output logic [NUM_CH-1:0] out_enable,
	output logic [NUM_CH-1:0] out_invert,
	output logic [NUM_CH-1:0] align_pulse,
	output logic reset_busy,
	output logic [NUM_CH-1:0][5:0] post_div_ratio,
	output logic [NUM_CH-1:0][7:0] eff_freq_step,
	output logic signed [NUM_CH-1:0][PHASE_W-1:0] phase_offset,
	output logic signed [NUM_CH-1:0][FREQ_W-1:0] freq_offset,
	output logic [NUM_CH-1:0] spread_en,
	output logic [NUM_CH-1:0][7:0] spread_down_amt,
	output logic [NUM_CH-1:0][7:0] spread_upshift,
	output logic [7:0] spread_rate,
	output logic feedback_en,
	output logic [1:0] feedback_chan,
	output logic feedback_diff
);
	localparam int CFG_W = NUM_CH * 8 * 5 + 16;

	// ****************************************************************
	// Link domain: register file
	// ****************************************************************
	logic [7:0] soft_reset_control_r;
	logic [NUM_CH-1:0][7:0] chan_cfg_r;
	logic [NUM_CH-1:0][7:0] freq_step_r;
	logic [NUM_CH-1:0][7:0] phase_step_r;
	logic [NUM_CH-1:0][7:0] init_phase_r;
	logic [NUM_CH-1:0][7:0] spread_amt_r;
	logic [7:0] global_r;
	logic [7:0] spread_rate_r;
	logic [7:0] step_cmd_r;
	logic soft_tgl_r;
	logic step_tgl_r;
	logic busy_link;
	logic [CFG_W-1:0] cfg_link;

	// Register writes; soft reset never touches these
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			soft_reset_control_r <= RST_SOFT_RESET;
			chan_cfg_r <= {NUM_CH{RST_CHAN_CFG}};
			freq_step_r <= {NUM_CH{RST_STEP}};
			phase_step_r <= {NUM_CH{RST_STEP}};
			init_phase_r <= {NUM_CH{RST_INIT_PHASE}};
			spread_amt_r <= {NUM_CH{RST_SPREAD_AMT}};
			global_r <= RST_GLOBAL;
			spread_rate_r <= RST_SPREAD_RATE;
			step_cmd_r <= 8'h00;
		end else if (reg_wr) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (reg_addr == ADDR_CHAN_CFG + 8'(i)) chan_cfg_r[i] <= reg_wdata;
				if (reg_addr == ADDR_FREQ_STEP + 8'(i)) freq_step_r[i] <= reg_wdata;
				if (reg_addr == ADDR_PHASE_STEP + 8'(i)) phase_step_r[i] <= reg_wdata;
				if (reg_addr == ADDR_INIT_PHASE + 8'(i)) init_phase_r[i] <= reg_wdata;
				if (reg_addr == ADDR_SPREAD_AMT + 8'(i)) spread_amt_r[i] <= reg_wdata;
			end
			if (reg_addr == ADDR_SOFT_RESET) soft_reset_control_r <= reg_wdata;
			if (reg_addr == ADDR_GLOBAL) global_r <= reg_wdata;
			if (reg_addr == ADDR_SPREAD_RATE) spread_rate_r <= reg_wdata;
			if (reg_addr == ADDR_STEP_CMD) step_cmd_r <= reg_wdata;
		end
	end

	// Event toggles toward the core clock
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			soft_tgl_r <= 1'b0;
			step_tgl_r <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == ADDR_SOFT_RESET && reg_wdata == SOFT_RESET_VALUE) begin
				soft_tgl_r <= ~soft_tgl_r;
			end
			if (reg_wr && reg_addr == ADDR_STEP_CMD) begin
				step_tgl_r <= ~step_tgl_r;
			end
		end
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= 8'h00;
			for (int i = 0; i < NUM_CH; i++) begin
				if (reg_addr == ADDR_CHAN_CFG + 8'(i)) reg_rdata <= chan_cfg_r[i];
				if (reg_addr == ADDR_FREQ_STEP + 8'(i)) reg_rdata <= freq_step_r[i];
				if (reg_addr == ADDR_PHASE_STEP + 8'(i)) reg_rdata <= phase_step_r[i];
				if (reg_addr == ADDR_INIT_PHASE + 8'(i)) reg_rdata <= init_phase_r[i];
				if (reg_addr == ADDR_SPREAD_AMT + 8'(i)) reg_rdata <= spread_amt_r[i];
			end
			if (reg_addr == ADDR_SOFT_RESET) reg_rdata <= soft_reset_control_r;
			if (reg_addr == ADDR_GLOBAL) reg_rdata <= global_r;
			if (reg_addr == ADDR_SPREAD_RATE) reg_rdata <= spread_rate_r;
			if (reg_addr == ADDR_STEP_CMD) reg_rdata <= step_cmd_r;
			if (reg_addr == ADDR_STATUS) reg_rdata <= {7'h00, busy_link};
		end
	end

	assign cfg_link = {global_r, spread_rate_r, spread_amt_r, init_phase_r, phase_step_r, freq_step_r, chan_cfg_r};

	sync_bits #(.W(1)) u_busy_sync (
		.clk(link_clk),
		.rst(rst),
		.d(reset_busy),
		.q(busy_link)
	);

	// ****************************************************************
	// Core domain: crossings
	// ****************************************************************
	logic [CFG_W-1:0] cfg_s;
	logic [CFG_W-1:0] cfg_q_r;
	logic [CFG_W-1:0] cfg_r;
	logic [1:0] tgl_s;
	logic [3:0] pin_s;
	logic [1:0] tgl_d_r;
	logic [3:0] pin_d_r;
	logic [7:0] glob_s;
	logic [7:0] rate_s;
	chan_cfg_t [NUM_CH-1:0] chcfg_s;
	logic [NUM_CH-1:0][7:0] fstep_s;
	logic [NUM_CH-1:0][7:0] pstep_s;
	logic [NUM_CH-1:0][7:0] init_s;
	logic [NUM_CH-1:0][7:0] amt_s;
	logic [NUM_CH-1:0][7:0] chraw_s;
	step_cmd_t cmd_s;
	logic soft_evt;
	logic step_evt;
	logic [3:0] pin_evt;

	sync_bits #(.W(CFG_W)) u_cfg_sync (
		.clk(clk),
		.rst(rst),
		.d(cfg_link),
		.q(cfg_s)
	);

	sync_bits #(.W(2)) u_tgl_sync (
		.clk(clk),
		.rst(rst),
		.d({step_tgl_r, soft_tgl_r}),
		.q(tgl_s)
	);

	// Step pins are asynchronous; 200 MHz sampling easily follows 1.5 MHz
	sync_bits #(.W(4)) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.d({phase_step_down_pin, phase_step_up_pin, freq_step_down_pin, freq_step_up_pin}),
		.q(pin_s)
	);

	// Word is taken only once two samples agree, so a skewed update never lands
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q_r <= '0;
			cfg_r <= '0;
		end else begin
			cfg_q_r <= cfg_s;
			if (cfg_q_r == cfg_s) cfg_r <= cfg_s;
		end
	end

	assign {glob_s, rate_s, amt_s, init_s, pstep_s, fstep_s, chraw_s} = cfg_r;
	assign chcfg_s = chraw_s;
	assign cmd_s = step_cmd_r[5:0];

	// Edge detectors behind the synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tgl_d_r <= 2'b00;
			pin_d_r <= 4'h0;
		end else begin
			tgl_d_r <= tgl_s;
			pin_d_r <= pin_s;
		end
	end

	assign soft_evt = tgl_s[0] ^ tgl_d_r[0];
	assign step_evt = tgl_s[1] ^ tgl_d_r[1];
	assign pin_evt = pin_s & ~pin_d_r;

	// ****************************************************************
	// Soft reset sequencer
	// ****************************************************************
	rst_state_t state_r;
	logic [31:0] lock_cnt_r;
	logic calib;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= RS_IDLE;
			lock_cnt_r <= 32'h0;
		end else begin
			case (state_r)
				RS_IDLE: begin
					if (soft_evt) state_r <= RS_DISABLE;
				end
				RS_DISABLE: begin
					state_r <= RS_CALIB;
				end
				RS_CALIB: begin
					lock_cnt_r <= 32'h0;
					state_r <= glob_s[0] ? RS_ENABLE : RS_LOCK_WAIT;
				end
				RS_LOCK_WAIT: begin
					lock_cnt_r <= lock_cnt_r + 32'h1;
					if (lock_cnt_r >= 32'(LOCK_CYCLES - 1)) state_r <= RS_ENABLE;
				end
				RS_ENABLE: begin
					state_r <= RS_IDLE;
				end
				default: begin
					state_r <= RS_IDLE;
				end
			endcase
		end
	end

	assign calib = (state_r == RS_CALIB);

	// Output gating and alignment strobe per channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_enable <= '0;
			out_invert <= '0;
			align_pulse <= '0;
			reset_busy <= 1'b0;
		end else begin
			reset_busy <= (state_r != RS_IDLE) || soft_evt;
			for (int i = 0; i < NUM_CH; i++) begin
				out_enable[i] <= chcfg_s[i].always_on ||
					!(state_r == RS_DISABLE || calib || state_r == RS_LOCK_WAIT);
				out_invert[i] <= chcfg_s[i].invert;
				align_pulse[i] <= calib && chcfg_s[i].post_div == 3'h0;
			end
		end
	end

	// ****************************************************************
	// Per-channel stepping, divider and spread
	// ****************************************************************
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			logic sel;
			logic f_up;
			logic f_dn;
			logic p_up;
			logic p_dn;
			logic [2:0] div_code;
			logic signed [PHASE_W-1:0] init_val;
			logic [7:0] amt_c;

			assign sel = step_evt && cmd_s.chan == 2'(ch) && state_r == RS_IDLE;
			assign f_up = (sel && cmd_s.freq_up) || (ch == 0 && pin_evt[0] && state_r == RS_IDLE);
			assign f_dn = (sel && cmd_s.freq_down) || (ch == 0 && pin_evt[1] && state_r == RS_IDLE);
			assign p_up = (sel && cmd_s.phase_up) || (ch == 0 && pin_evt[2] && state_r == RS_IDLE);
			assign p_dn = (sel && cmd_s.phase_down) || (ch == 0 && pin_evt[3] && state_r == RS_IDLE);
			assign div_code = (chcfg_s[ch].post_div > POST_DIV_MAX) ? POST_DIV_MAX : chcfg_s[ch].post_div;
			// Initial offset counts only at unity ratio
			assign init_val = (div_code == 3'h0) ?
				PHASE_W'($signed(init_s[ch]) * $signed({1'b0, INIT_PHASE_UNIT})) : '0;

			// Phase offset in 20 ps steps, clamped to 45 ns
			step_accum #(.W(PHASE_W), .LIMIT(PHASE_LIMIT)) u_phase (
				.clk(clk),
				.rst(rst),
				.load(calib),
				.load_val(init_val),
				.up(p_up),
				.down(p_dn),
				.step(pstep_s[ch]),
				.value(phase_offset[ch])
			);

			// Frequency offset in exact ppm units
			step_accum #(.W(FREQ_W), .LIMIT(FREQ_LIMIT)) u_freq (
				.clk(clk),
				.rst(rst),
				.load(calib),
				.load_val('0),
				.up(f_up),
				.down(f_dn),
				.step(fstep_s[ch]),
				.value(freq_offset[ch])
			);

			// Spread amount clamped by mode
			always_comb begin
				amt_c = amt_s[ch];
				if (amt_c < SS_AMT_MIN) amt_c = SS_AMT_MIN;
				if (chcfg_s[ch].spread_center && amt_c > SS_CENTER_MAX) amt_c = SS_CENTER_MAX;
				if (!chcfg_s[ch].spread_center && amt_c > SS_DOWN_MAX) amt_c = SS_DOWN_MAX;
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					post_div_ratio[ch] <= 6'h01;
					eff_freq_step[ch] <= 8'h00;
					spread_en[ch] <= 1'b0;
					spread_down_amt[ch] <= 8'h00;
					spread_upshift[ch] <= 8'h00;
				end else begin
					post_div_ratio[ch] <= 6'h01 << div_code;
					eff_freq_step[ch] <= fstep_s[ch] >> div_code;
					spread_en[ch] <= chcfg_s[ch].spread_en;
					spread_down_amt[ch] <= chcfg_s[ch].spread_center ? 8'(amt_c << 1) : amt_c;
					spread_upshift[ch] <= chcfg_s[ch].spread_center ? amt_c : 8'h00;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Shared spread rate and zero-delay feedback
	// ****************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spread_rate <= RST_SPREAD_RATE;
			feedback_en <= 1'b0;
			feedback_chan <= 2'h0;
			feedback_diff <= 1'b0;
		end else begin
			if (rate_s < SS_RATE_MIN) begin
				spread_rate <= SS_RATE_MIN;
			end else if (rate_s > SS_RATE_MAX) begin
				spread_rate <= SS_RATE_MAX;
			end else begin
				spread_rate <= rate_s;
			end
			feedback_en <= glob_s[1];
			feedback_chan <= glob_s[3:2];
			feedback_diff <= glob_s[4];
		end
	end
endmodule : clock_output_adjust_and_reset
`default_nettype wire

// [common/clock_adjust_pkg.sv]
// Shared constants, register map and types of the clock output adjust block
package clock_adjust_pkg;
	localparam int NUM_CH = 4;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_SOFT_RESET = 8'hf6;
	localparam logic [7:0] ADDR_CHAN_CFG = 8'h10;
	localparam logic [7:0] ADDR_FREQ_STEP = 8'h14;
	localparam logic [7:0] ADDR_PHASE_STEP = 8'h18;
	localparam logic [7:0] ADDR_INIT_PHASE = 8'h1c;
	localparam logic [7:0] ADDR_SPREAD_AMT = 8'h24;
	localparam logic [7:0] ADDR_STEP_CMD = 8'h20;
	localparam logic [7:0] ADDR_GLOBAL = 8'h21;
	localparam logic [7:0] ADDR_SPREAD_RATE = 8'h22;
	localparam logic [7:0] ADDR_STATUS = 8'h28;
	localparam logic [7:0] SOFT_RESET_VALUE = 8'h02;
	localparam int SOFT_RESET_BIT = 1;
	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_SOFT_RESET = 8'h00;
	localparam logic [7:0] RST_CHAN_CFG = 8'h00;
	localparam logic [7:0] RST_STEP = 8'h01;
	localparam logic [7:0] RST_INIT_PHASE = 8'h00;
	localparam logic [7:0] RST_GLOBAL = 8'h00;
	localparam logic [7:0] RST_SPREAD_RATE = 8'h3f;
	localparam logic [7:0] RST_SPREAD_AMT = 8'h05;
	// ****************************************************************
	// Limits (spread in 0.1 %, rate in 0.5 kHz, phase in 20 ps steps)
	// ****************************************************************
	localparam logic [7:0] SS_RATE_MIN = 8'h3c;
	localparam logic [7:0] SS_RATE_MAX = 8'h7e;
	localparam logic [7:0] SS_AMT_MIN = 8'h01;
	localparam logic [7:0] SS_CENTER_MAX = 8'h19;
	localparam logic [7:0] SS_DOWN_MAX = 8'h32;
	localparam int PHASE_W = 13;
	localparam logic [12:0] PHASE_LIMIT = 13'h08ca;
	localparam logic [4:0] INIT_PHASE_UNIT = 5'h12;
	localparam int FREQ_W = 16;
	localparam logic [15:0] FREQ_LIMIT = 16'h7fff;
	localparam logic [2:0] POST_DIV_MAX = 3'h5;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int LOCK_WAIT_MS = 25;
	localparam int CLK_KHZ = 200000;
	localparam int LOCK_WAIT_CYC = LOCK_WAIT_MS * CLK_KHZ;
	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic spare;
		logic spread_center;
		logic spread_en;
		logic invert;
		logic always_on;
		logic [2:0] post_div;
	} chan_cfg_t;
	typedef struct packed {
		logic phase_down;
		logic phase_up;
		logic freq_down;
		logic freq_up;
		logic [1:0] chan;
	} step_cmd_t;
	typedef enum {RS_IDLE, RS_DISABLE, RS_CALIB, RS_LOCK_WAIT, RS_ENABLE} rst_state_t;
endpackage : clock_adjust_pkg

// [logic/sync_bits.sv]
// Two flip-flop synchroniser for levels and toggles
`timescale 1ns/10ps
`default_nettype none
module sync_bits #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : sync_bits
`default_nettype wire

// [logic/step_accum.sv]
// Saturating signed step accumulator with load
`timescale 1ns/10ps
`default_nettype none
module step_accum #(
	parameter int W = 13,
	parameter logic [W-1:0] LIMIT = '1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic signed [W-1:0] load_val,
	input wire logic up,
	input wire logic down,
	input wire logic [7:0] step,
	output logic signed [W-1:0] value
);
	logic signed [W+1:0] sum;
	logic signed [W+1:0] lim;

	// Next value, clamped to plus or minus the limit
	always_comb begin
		lim = $signed({2'b00, LIMIT});
		sum = {{2{value[W-1]}}, value};
		if (load) begin
			sum = {{2{load_val[W-1]}}, load_val};
		end else if (up && !down) begin
			sum = sum + $signed({{(W - 6){1'b0}}, step});
		end else if (down && !up) begin
			sum = sum - $signed({{(W - 6){1'b0}}, step});
		end
		if (sum > lim) begin
			sum = lim;
		end else if (sum < -lim) begin
			sum = -lim;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			value <= '0;
		end else begin
			value <= sum[W-1:0];
		end
	end
endmodule : step_accum
`default_nettype wire

// [tb/clock_adjust_asserts.sv]
// Concurrent checks on the ports of the clock output adjust block
`timescale 1ns/10ps
`default_nettype none
module clock_adjust_asserts
	import clock_adjust_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_WAIT_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [NUM_CH-1:0] out_enable,
	input wire logic [NUM_CH-1:0] align_pulse,
	input wire logic reset_busy,
	input wire logic [NUM_CH-1:0][5:0] post_div_ratio,
	input wire logic signed [NUM_CH-1:0][PHASE_W-1:0] phase_offset,
	input wire logic [NUM_CH-1:0][7:0] spread_down_amt,
	input wire logic [NUM_CH-1:0][7:0] spread_upshift,
	input wire logic [7:0] spread_rate
);
	// ****
	// Helper state
	// ****
	logic ovrd_r;
	int busy_r;
	logic [NUM_CH-1:0] unity;
	// Override bit as last written by the host
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			ovrd_r <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_GLOBAL) begin
			ovrd_r <= reg_wdata[0];
		end
	end
	// Length of the current busy stretch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_r <= 0;
		end else if (!reset_busy) begin
			busy_r <= 0;
		end else begin
			busy_r <= busy_r + 1;
		end
	end
	// Channels running at unity post division
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			unity[i] = post_div_ratio[i] == 6'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ****
	// Properties
	// ****
	property p_div_ratio;
		$onehot(post_div_ratio[0]) && $onehot(post_div_ratio[3]);
	endproperty
	a_div_ratio: assert property (p_div_ratio) else $error("bad divider ratio");
	property p_rate_range;
		spread_rate >= SS_RATE_MIN && spread_rate <= SS_RATE_MAX;
	endproperty
	a_rate_range: assert property (p_rate_range) else $error("spread rate out of range");
	property p_phase_range;
		$signed(phase_offset[1]) <= $signed({1'b0, PHASE_LIMIT}) && $signed(phase_offset[1]) >= -$signed({1'b0, PHASE_LIMIT});
	endproperty
	a_phase_range: assert property (p_phase_range) else $error("phase offset out of range");
	property p_lock_wait;
		$fell(reset_busy) && !ovrd_r |-> busy_r >= LOCK_CYCLES;
	endproperty
	a_lock_wait: assert property (p_lock_wait) else $error("lock wait cut short");
	property p_reenable;
		$fell(reset_busy) |-> (out_enable == '1) [*4];
	endproperty
	a_reenable: assert property (p_reenable) else $error("outputs not back on");
	property p_align_busy;
		|align_pulse |-> reset_busy ##1 align_pulse == '0;
	endproperty
	a_align_busy: assert property (p_align_busy) else $error("stray alignment pulse");
	property p_align_div;
		(align_pulse & ~unity) == '0;
	endproperty
	a_align_div: assert property (p_align_div) else $error("aligned a divided output");
	property p_spread_lim;
		spread_down_amt[3] <= SS_DOWN_MAX && spread_upshift[3] <= SS_CENTER_MAX;
	endproperty
	a_spread_lim: assert property (p_spread_lim) else $error("spread amount too large");
	property p_center;
		spread_upshift[3] != 8'h00 |-> spread_down_amt[3] == {spread_upshift[3][6:0], 1'b0};
	endproperty
	a_center: assert property (p_center) else $error("center spread mismatch");
endmodule : clock_adjust_asserts
bind clock_output_adjust_and_reset clock_adjust_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.clk(clk), .rst(rst),
	.link_clk(link_clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .out_enable(out_enable),
	.align_pulse(align_pulse), .reset_busy(reset_busy), .post_div_ratio(post_div_ratio),
	.phase_offset(phase_offset), .spread_down_amt(spread_down_amt), .spread_upshift(spread_upshift),
	.spread_rate(spread_rate));
`default_nettype wire

// [tb/reg_host.sv]
// Host model driving the register port of the clock adjust block
`timescale 1ns/10ps
`default_nettype none
module reg_host (
	input wire logic link_clk,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// ****
	// Register port tasks
	// ****
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One strobe cycle, data scrambled once released
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge link_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge link_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr
	// Address held until the registered data has settled
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge link_clk);
		reg_addr = a;
		@(negedge link_clk);
		@(negedge link_clk);
		d = reg_rdata;
	endtask : rd
endmodule : reg_host
`default_nettype wire

// [tb/clock_output_adjust_and_reset_test.sv]
// Self-checking bench of the clock output adjust block
`timescale 1ns/10ps
`default_nettype none
module clock_output_adjust_and_reset_test;
	import clock_adjust_pkg::*;
	// ****
	// Clocks, wiring and bookkeeping
	// ****
	localparam int LOCK = 20;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] pins = 4'h0;
	logic reg_wr;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, spread_rate, rd;
	logic [NUM_CH-1:0] out_enable, out_invert, align_pulse, spread_en, aligned;
	logic reset_busy, feedback_en, feedback_diff;
	logic [1:0] feedback_chan;
	logic [NUM_CH-1:0][5:0] post_div_ratio;
	logic [NUM_CH-1:0][7:0] eff_freq_step, spread_down_amt, spread_upshift;
	logic signed [NUM_CH-1:0][PHASE_W-1:0] phase_offset;
	logic signed [NUM_CH-1:0][FREQ_W-1:0] freq_offset;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	always #2.5 clk = ~clk;
	initial begin
		#1.3;
		forever #15 link_clk = ~link_clk;
	end
	clock_output_adjust_and_reset #(.LOCK_CYCLES(LOCK)) DUT (.clk(clk), .rst(rst), .link_clk(link_clk),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.freq_step_up_pin(pins[0]), .freq_step_down_pin(pins[1]), .phase_step_up_pin(pins[2]),
		.phase_step_down_pin(pins[3]), .out_enable(out_enable), .out_invert(out_invert),
		.align_pulse(align_pulse), .reset_busy(reset_busy), .post_div_ratio(post_div_ratio),
		.eff_freq_step(eff_freq_step), .phase_offset(phase_offset), .freq_offset(freq_offset),
		.spread_en(spread_en), .spread_down_amt(spread_down_amt), .spread_upshift(spread_upshift),
		.spread_rate(spread_rate), .feedback_en(feedback_en), .feedback_chan(feedback_chan),
		.feedback_diff(feedback_diff));
	reg_host host (.link_clk(link_clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata));
	// Channels that saw an alignment pulse
	always @(posedge clk) begin
		aligned <= rst ? 4'h0 : aligned | align_pulse;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			$display("[ERR] %0t timeout", $time);
			summarize();
		end
	end
	// ****
	// Tasks
	// ****
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task w(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d);
		repeat (4) @(negedge link_clk);
	endtask : w
	task rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rd);
		check(16'(rd), 16'(e));
	endtask : rchk
	task pulse(input int i);
		@(negedge clk);
		pins[i] = 1'b1;
		repeat (4) @(negedge clk);
		pins[i] = 1'b0;
		repeat (8) @(negedge clk);
	endtask : pulse
	task wait_busy(input logic lvl);
		n = 0;
		while (reset_busy !== lvl && n < 200) begin
			@(negedge clk);
			n++;
		end
		check(16'(reset_busy), 16'(lvl));
	endtask : wait_busy
	task summarize;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	// ****
	// Tests
	// ****
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		rchk(ADDR_SPREAD_RATE, RST_SPREAD_RATE);
		rchk(ADDR_SPREAD_AMT, RST_SPREAD_AMT);
		rchk(ADDR_FREQ_STEP, RST_STEP);
		rchk(ADDR_SOFT_RESET, RST_SOFT_RESET);
		rchk(8'h80, 8'h00);
		check(16'(spread_rate), 16'(RST_SPREAD_RATE));
		check(16'(out_enable), 16'h000f);
		$display("test reset values done");
		w(ADDR_FREQ_STEP, 8'h40);
		for (int c = 0; c < 6; c++) begin
			w(ADDR_CHAN_CFG, 8'(c));
			check(16'(post_div_ratio[0]), 16'(1 << c));
			check(16'(eff_freq_step[0]), 16'(8'h40 >> c));
		end
		$display("test post divider done");
		w(ADDR_CHAN_CFG, 8'h00);
		w(ADDR_CHAN_CFG + 8'h01, 8'h08);
		w(ADDR_CHAN_CFG + 8'h02, 8'h15);
		w(ADDR_CHAN_CFG + 8'h03, 8'h6f);
		w(ADDR_SPREAD_AMT + 8'h03, 8'h0a);
		check(16'(out_invert), 16'h0004);
		check(16'(post_div_ratio[3]), 16'h0020);
		check(16'(spread_en), 16'h0008);
		check(16'({spread_upshift[3], spread_down_amt[3]}), 16'h0a14);
		w(ADDR_SPREAD_RATE, 8'h10);
		check(16'(spread_rate), 16'(SS_RATE_MIN));
		w(ADDR_SPREAD_RATE, 8'hff);
		check(16'(spread_rate), 16'(SS_RATE_MAX));
		w(ADDR_GLOBAL, 8'h1e);
		check(16'({feedback_en, feedback_chan, feedback_diff}), 16'h000f);
		$display("test channel setup done");
		w(ADDR_FREQ_STEP, 8'h03);
		w(ADDR_STEP_CMD, 8'h04);
		check(freq_offset[0], 16'h0003);
		w(ADDR_STEP_CMD, 8'h08);
		w(ADDR_STEP_CMD, 8'h08);
		check(freq_offset[0], 16'hfffd);
		w(ADDR_FREQ_STEP + 8'h02, 8'h07);
		w(ADDR_STEP_CMD, 8'h06);
		check(freq_offset[2], 16'h0007);
		w(ADDR_PHASE_STEP + 8'h01, 8'h05);
		w(ADDR_STEP_CMD, 8'h11);
		w(ADDR_STEP_CMD, 8'h21);
		w(ADDR_STEP_CMD, 8'h21);
		check(16'(phase_offset[1]), 16'h1ffb);
		w(ADDR_PHASE_STEP + 8'h01, 8'hff);
		repeat (10) w(ADDR_STEP_CMD, 8'h11);
		check(16'(phase_offset[1]), 16'(PHASE_LIMIT));
		$display("test register steps done");
		pulse(0);
		pulse(0);
		pulse(3);
		check(freq_offset[0], 16'h0003);
		check(freq_offset[2], 16'h0007);
		check(16'(phase_offset[0]), 16'h1fff);
		$display("test step pins done");
		w(ADDR_INIT_PHASE, 8'h02);
		w(ADDR_INIT_PHASE + 8'h02, 8'h03);
		host.wr(ADDR_SOFT_RESET, SOFT_RESET_VALUE);
		wait_busy(1'b1);
		repeat (3) @(negedge clk);
		check(16'(out_enable), 16'h000a);
		wait_busy(1'b0);
		check(16'(n >= LOCK - 4), 16'h0001);
		check(16'(out_enable), 16'h000f);
		check(16'(aligned), 16'h0003);
		check(16'(phase_offset[0]), 16'h0024);
		check(16'(phase_offset[2]), 16'h0000);
		check(freq_offset[0], 16'h0000);
		rchk(ADDR_CHAN_CFG + 8'h02, 8'h15);
		rchk(ADDR_SOFT_RESET, SOFT_RESET_VALUE);
		w(ADDR_GLOBAL, 8'h1f);
		w(ADDR_SOFT_RESET, 8'h00);
		host.wr(ADDR_SOFT_RESET, SOFT_RESET_VALUE);
		wait_busy(1'b1);
		repeat (3) @(negedge clk);
		wait_busy(1'b0);
		check(16'(n < 10), 16'h0001);
		$display("test soft reset done");
		summarize();
	end
endmodule : clock_output_adjust_and_reset_test
`default_nettype wire
